// ==== hdl/sdh_defines.vh ====
`ifndef SDH_DEFINES_VH
`define SDH_DEFINES_VH
`define SDH_DUMMY_CLKS 8'd80
`define SDH_CMD_BITS 6'd48
`define SDH_RESP_TMO 16'd2000
`define SDH_CLK_HALF 8'd2
`define SDH_OCR_BUSY 31
`define SDH_OCR_VOLT 32'h00ff8000
`define SDH_TYPE_HI 31
`define SDH_TYPE_LO 24
`define SDH_ARG_APP 32'h00000000
`define SDH_BUS_4BIT 32'h00000002
`define SDH_BUS_1BIT 32'h00000000
`endif

// ==== hdl/sdh_init_host.v ====
`timescale 1ns/1ps
`include "sdh_defines.vh"
// Operation
// - Host runs more than 74 dummy bus clocks before its first command.
// - Data bus width is chosen by the WIDE_BUS parameter, one or four lines.
// - Host holds DAT3 low at CMD0 for SPI, high for SD.
// - Card drops DAT3 pull-up on ACMD42; host sends it after CMD7 selects the card.
// - Host sends each command serially on CMD, starting an operation.
// - Every token opens with a start bit and ends with a stop bit.
// - Each card gets its own command and data lines.
// - Identification begins with ACMD41 carrying a zero argument.
// - Host repeats ACMD41 until bit 31 is set; timeout means no card.
// - Host checks ACMD13 card type; nonzero top byte aborts.
// - Host sets bus width with ACMD6 after returning to transfer.
// - Host bus clock never exceeds 50MHz.
module sdh_init_host #(
	parameter WIDE_BUS = 1,
	parameter SPI_MODE = 0
)(
	input wire clock,
	input wire sys_rst,
	input wire start,
	output reg sd_clk_r,
	output reg cmd_out_r,
	output reg cmd_oe_r,
	input wire cmd_in,
	output reg dat3_out_r,
	output reg dat3_oe_r,
	input wire [3:0] dat_in,
	output reg busy_r,
	output reg done_r,
	output reg fail_r,
	output reg bus4_r,
	output reg [15:0] rca_r,
	output reg resp_valid_r,
	output reg [31:0] resp_data_r,
	input wire resp_ready
);
	// ****************************************
	// Input synchronisers and bus clock divider
	// ****************************************
	reg cmd_s1_r, cmd_s2_r;
	reg [7:0] div_r;
	wire tick = (div_r == `SDH_CLK_HALF - 8'd1);
	wire rise = tick & ~sd_clk_r;
	wire fall = tick & sd_clk_r;
	always @(posedge clock or posedge sys_rst)
		if (sys_rst)
		begin
			cmd_s1_r <= 1'b1;
			cmd_s2_r <= 1'b1;
			div_r <= 8'h00;
			sd_clk_r <= 1'b0;
		end
		else
		begin
			cmd_s1_r <= cmd_in;
			cmd_s2_r <= cmd_s1_r;
			div_r <= tick ? 8'h00 : div_r + 8'h01;
			if (tick)
				sd_clk_r <= ~sd_clk_r;
		end
	// ****************************************
	// Two-entry response buffer
	// ****************************************
	reg [31:0] buf_d0_r, buf_d1_r;
	reg [1:0] buf_cnt_r;
	reg push;
	reg [31:0] push_d;
	wire buf_ready = (buf_cnt_r != 2'd2);
	wire pop = resp_valid_r & resp_ready;
	always @(posedge clock or posedge sys_rst)
		if (sys_rst)
		begin
			buf_d0_r <= 32'h00000000;
			buf_d1_r <= 32'h00000000;
			buf_cnt_r <= 2'd0;
			resp_valid_r <= 1'b0;
			resp_data_r <= 32'h00000000;
		end
		else
		begin
			case ({push & buf_ready, pop})
				2'b10:
				begin
					if (buf_cnt_r == 2'd0)
						buf_d0_r <= push_d;
					else
						buf_d1_r <= push_d;
					buf_cnt_r <= buf_cnt_r + 2'd1;
				end
				2'b01:
				begin
					buf_d0_r <= buf_d1_r;
					buf_cnt_r <= buf_cnt_r - 2'd1;
				end
				2'b11:
				begin
					if (buf_cnt_r == 2'd1)
						buf_d0_r <= push_d;
					else
					begin
						buf_d0_r <= buf_d1_r;
						buf_d1_r <= push_d;
					end
				end
				default:
					buf_cnt_r <= buf_cnt_r;
			endcase
			resp_valid_r <= 1'b0;
			resp_data_r <= buf_d0_r;
			if (buf_cnt_r != 2'd0 && !pop)
				resp_valid_r <= 1'b1;
		end
	// ****************************************
	// Command sequencer
	// ****************************************
	localparam ST_IDLE = 4'd0, ST_DUMMY = 4'd1, ST_SEND = 4'd2, ST_WAIT = 4'd3;
	localparam ST_RESP = 4'd4, ST_NEXT = 4'd5, ST_HOLD = 4'd6, ST_DONE = 4'd7, ST_FAIL = 4'd8;
	reg [3:0] st_r;
	reg [3:0] step_r;
	reg [7:0] cnt_r;
	reg [47:0] sh_r;
	reg [135:0] rx_r;
	reg [7:0] rx_len_r;
	reg [15:0] tmo_r;
	reg [5:0] idx;
	reg [31:0] arg;
	reg [7:0] rlen;
	reg no_resp;
	reg [1:0] phase_r;
	always @*
	begin
		idx = 6'd0;
		arg = 32'h00000000;
		rlen = 8'd48;
		no_resp = 1'b0;
		case (step_r)
			4'd0: begin idx = 6'd0; no_resp = 1'b1; end
			4'd1: idx = 6'd55;
			4'd2: arg = 32'h00000000;
			4'd3: idx = 6'd55;
			4'd4: arg = `SDH_OCR_VOLT;
			4'd5: begin idx = 6'd2; rlen = 8'd136; end
			4'd6: idx = 6'd3;
			4'd7: begin idx = 6'd7; arg = {rca_r, 16'h0000}; end
			4'd8: begin idx = 6'd55; arg = {rca_r, 16'h0000}; end
			4'd9: idx = 6'd42;
			4'd10: begin idx = 6'd55; arg = {rca_r, 16'h0000}; end
			4'd11: idx = 6'd13;
			4'd12: begin idx = 6'd7; arg = 32'h00000000; end
			4'd13: begin idx = 6'd9; arg = {rca_r, 16'h0000}; rlen = 8'd136; end
			4'd14: begin idx = 6'd10; arg = {rca_r, 16'h0000}; rlen = 8'd136; end
			default: begin idx = 6'd7; arg = {rca_r, 16'h0000}; end
		endcase
		if (step_r == 4'd2 || step_r == 4'd4)
			idx = 6'd41;
		if (step_r == 4'd9 || step_r == 4'd11)
			idx = (step_r == 4'd9) ? 6'd42 : 6'd13;
		// The width change is an application command, so it needs its own prefix first.
		if (phase_r == 2'd1)
		begin
			idx = 6'd55;
			arg = {rca_r, 16'h0000};
		end
		else if (phase_r == 2'd2)
		begin
			idx = 6'd6;
			arg = `SDH_BUS_4BIT;
		end
		push = (st_r == ST_NEXT);
		push_d = rx_r[39:8];
	end
	always @(posedge clock or posedge sys_rst)
		if (sys_rst)
		begin
			st_r <= ST_IDLE;
			step_r <= 4'd0;
			cnt_r <= 8'h00;
			sh_r <= 48'h000000000000;
			rx_r <= 136'h0;
			rx_len_r <= 8'h00;
			tmo_r <= 16'h0000;
			phase_r <= 2'd0;
			cmd_out_r <= 1'b1;
			cmd_oe_r <= 1'b0;
			dat3_out_r <= 1'b1;
			dat3_oe_r <= 1'b0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			fail_r <= 1'b0;
			bus4_r <= 1'b0;
			rca_r <= 16'h0000;
		end
		else
			case (st_r)
				ST_IDLE:
					if (start)
					begin
						busy_r <= 1'b1;
						done_r <= 1'b0;
						fail_r <= 1'b0;
						bus4_r <= 1'b0;
						step_r <= 4'd0;
						cnt_r <= 8'h00;
						phase_r <= 2'd0;
						rx_r <= 136'h0;
						dat3_oe_r <= 1'b1;
						dat3_out_r <= (SPI_MODE == 0);
						st_r <= ST_DUMMY;
					end
				ST_DUMMY:
					if (rise)
					begin
						cnt_r <= cnt_r + 8'h01;
						if (cnt_r == `SDH_DUMMY_CLKS)
							st_r <= ST_HOLD;
					end
				ST_HOLD:
					if (fall)
					begin
						sh_r <= {2'b01, idx, arg, 7'h00, 1'b1};
						cnt_r <= 8'h00;
						cmd_oe_r <= 1'b1;
						st_r <= ST_SEND;
					end
				ST_SEND:
					if (fall)
					begin
						cmd_out_r <= sh_r[47];
						sh_r <= {sh_r[46:0], 1'b1};
						cnt_r <= cnt_r + 8'h01;
						if (cnt_r == {2'b00, `SDH_CMD_BITS})
						begin
							cmd_oe_r <= 1'b0;
							cmd_out_r <= 1'b1;
							if (step_r == 4'd1)
								dat3_oe_r <= 1'b0;
							tmo_r <= 16'h0000;
							rx_len_r <= 8'h00;
							st_r <= no_resp ? ST_NEXT : ST_WAIT;
						end
					end
				ST_WAIT:
					if (rise)
					begin
						tmo_r <= tmo_r + 16'h0001;
						if (!cmd_s2_r)
						begin
							rx_r <= 136'h0;
							rx_len_r <= 8'h01;
							st_r <= ST_RESP;
						end
						else if (tmo_r == `SDH_RESP_TMO)
							st_r <= ST_FAIL;
					end
				ST_RESP:
					if (rise)
					begin
						rx_r <= {rx_r[134:0], cmd_s2_r};
						rx_len_r <= rx_len_r + 8'h01;
						if (rx_len_r == rlen - 8'd1)
							st_r <= ST_NEXT;
					end
				ST_NEXT:
					if (buf_ready)
					begin
						st_r <= ST_HOLD;
						step_r <= step_r + 4'd1;
						if (step_r == 4'd4 && !rx_r[8 + `SDH_OCR_BUSY])
							step_r <= 4'd3;
						if (step_r == 4'd6)
							rca_r <= rx_r[39:24];
						if (step_r == 4'd11 && rx_r[8 + `SDH_TYPE_HI:8 + `SDH_TYPE_LO] != 8'h00)
							st_r <= ST_FAIL;
						if (step_r == 4'd15)
						begin
							step_r <= 4'd15;
							if (phase_r == 2'd2)
							begin
								bus4_r <= 1'b1;
								st_r <= ST_DONE;
							end
							else if (WIDE_BUS == 0)
								st_r <= ST_DONE;
							else
								phase_r <= phase_r + 2'd1;
						end
					end
				ST_DONE:
				begin
					busy_r <= 1'b0;
					done_r <= 1'b1;
					phase_r <= 2'd0;
					st_r <= ST_IDLE;
				end
				ST_FAIL:
				begin
					busy_r <= 1'b0;
					fail_r <= 1'b1;
					cmd_oe_r <= 1'b0;
					st_r <= ST_IDLE;
				end
				default:
					st_r <= ST_IDLE;
			endcase
endmodule // sdh_init_host

// ==== dv/sdh_init_props.sv ====
`timescale 1ns/1ps
module sdh_init_props #(
	parameter WIDE_BUS = 1,
	parameter SPI_MODE = 0
)(
	input wire clock,
	input wire sys_rst,
	input wire start,
	input wire sd_clk_r,
	input wire cmd_out_r,
	input wire cmd_oe_r,
	input wire cmd_in,
	input wire dat3_out_r,
	input wire dat3_oe_r,
	input wire [3:0] dat_in,
	input wire busy_r,
	input wire done_r,
	input wire fail_r,
	input wire bus4_r,
	input wire [15:0] rca_r,
	input wire resp_valid_r,
	input wire [31:0] resp_data_r,
	input wire resp_ready
);
	// ****
	// Checks
	// ****
	reg [7:0] rise_r;
	always @(posedge clock or posedge sys_rst)
		if (sys_rst)
			rise_r <= 8'h00;
		else if (!busy_r)
			rise_r <= 8'h00;
		else if ($rose(sd_clk_r) && rise_r != 8'hff)
			rise_r <= rise_r + 8'h01;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	dummy_clks_a: assert property (
		$rose(cmd_oe_r) |-> rise_r > 8'h4a) else $error("command before dummy clocks");
	clk_half_a: assert property (
		$rose(sd_clk_r) |-> sd_clk_r [*2] ##1 !sd_clk_r) else $error("bus clock too fast");
	dat3_level_a: assert property (
		dat3_oe_r |-> dat3_out_r == (SPI_MODE == 0)) else $error("mode pin level wrong");
	start_bit_a: assert property (
		$rose(cmd_oe_r) |-> ##[0:4] !cmd_out_r) else $error("no start bit");
	stop_bit_a: assert property (
		$fell(cmd_oe_r) |-> $past(cmd_out_r)) else $error("no stop bit");
	resp_hold_a: assert property (
		resp_valid_r && !resp_ready |=> resp_valid_r && $stable(resp_data_r)) else $error("response lost");
	done_addr_a: assert property (
		$rose(done_r) |-> !fail_r && rca_r != 16'h0000) else $error("bad completion");
	wide_bus_a: assert property (
		$rose(bus4_r) |-> WIDE_BUS != 0 && busy_r) else $error("bus widened wrongly");
endmodule // sdh_init_props
bind sdh_init_host sdh_init_props #(.WIDE_BUS(WIDE_BUS), .SPI_MODE(SPI_MODE)) u_props(.*);

// ==== dv/sdh_card_model.sv ====
`timescale 1ns/1ps
module sdh_card_model(
	input wire sd_clk,
	input wire cmd,
	input wire mute,
	input wire [7:0] type_hi,
	output reg cmd_o,
	output reg cmd_oe
);
	// ****
	// Card
	// ****
	reg [47:0] c;
	reg [135:0] r;
	reg [31:0] p;
	reg app;
	reg pu;
	integer i, n, polls;
	initial
	begin
		cmd_o = 1'b1;
		cmd_oe = 1'b0;
		polls = 0;
		app = 1'b0;
		pu = 1'b1;
		forever
		begin
			@(posedge sd_clk);
			if (cmd === 1'b0)
			begin
				c = 48'h0;
				for (i = 0; i < 47; i = i + 1)
				begin
					@(posedge sd_clk);
					c = {c[46:0], cmd};
				end
				p = 32'h0000_0900;
				n = 48;
				case (c[45:40])
				6'h00: polls = 0;
				6'h02, 6'h09, 6'h0a: n = 136;
				6'h03: p = 32'h5a3c_0000;
				6'h0d: p = {type_hi, 24'h0};
				6'h2a: pu = pu & ~app;
				6'h29:
				begin
					polls = polls + ((c[39:8] != 32'h0) ? 1 : 0);
					p = {polls > 2, 31'h00ff8000};
				end
				default: ;
				endcase
				app = c[45:40] == 6'h37;
				r = (n == 48) ? {2'b00, c[45:40], p, 8'h01, 88'h0} : {8'h3f, {4{32'h0f0f_0f0f}}};
				// The reset command has no response; answering it would collide with the next command.
				if (!mute && c[45:40] != 6'h00)
				begin
					repeat (2) @(negedge sd_clk);
					cmd_oe = 1'b1;
					for (i = 0; i < n; i = i + 1)
					begin
						cmd_o = r[135 - i];
						@(negedge sd_clk);
					end
					cmd_oe = 1'b0;
				end
			end
		end
	end
endmodule // sdh_card_model

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
	reg clock = 1'b0;
	reg sys_rst = 1'b1;
	reg start = 1'b0;
	reg resp_ready = 1'b0;
	reg mute = 1'b0;
	reg [7:0] type_hi = 8'h00;
	wire sd_clk_r, cmd_out_r, cmd_oe_r, dat3_out_r, dat3_oe_r, busy_r, done_r, fail_r, bus4_r, resp_valid_r;
	wire card_o, card_oe;
	wire [15:0] rca_r;
	wire [31:0] resp_data_r;
	// The CMD line is pulled up; a released DAT3 without its pull-up floats.
	wire cmd_w = cmd_oe_r ? cmd_out_r : (card_oe ? card_o : 1'b1);
	wire dat3_w = dat3_oe_r ? dat3_out_r : (u_card.pu | clock);
	logic [31:0] q[$];
	integer mismatches = 0;
	integer cmp_count = 0;
	// ****
	// Bench
	// ****
	sdh_init_host u_sdh_init_host(.*, .cmd_in(cmd_w), .dat_in({dat3_w, 3'b111}));
	sdh_card_model u_card(.sd_clk(sd_clk_r), .cmd(cmd_w), .mute(mute), .type_hi(type_hi), .cmd_o(card_o),
		.cmd_oe(card_oe));
	always #5 clock = ~clock;
	always @(posedge clock)
		if (resp_valid_r && resp_ready)
			q.push_back(resp_data_r);
	task chk(input [31:0] seen, input [31:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (seen !== exp)
		begin
			mismatches = mismatches + 1;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	end
	endtask
	task run(input integer stall);
		integer j;
	begin
		q.delete();
		@(posedge clock) #1 start = 1'b1;
		@(posedge clock) #1 start = 1'b0;
		repeat (stall) @(posedge clock);
		#1 resp_ready = 1'b1;
		for (j = 0; j < 40000 && done_r !== 1'b1 && fail_r !== 1'b1; j = j + 1)
			@(posedge clock);
		#1;
	end
	endtask
	task t_good;
	begin
		resp_ready = 1'b0;
		fork
			run(6000);
			#50000 chk(32'(q.size()), 32'h0);
		join
		chk(32'(done_r), 32'h1);
		chk(32'(fail_r), 32'h0);
		chk(32'(rca_r), 32'h5a3c);
		chk(32'(bus4_r), 32'h1);
		chk(q[0], 32'h0000_0000);
		chk(q[1], 32'h0000_0900);
		chk(q[6], 32'h00ff8000);
		chk(q[8], 32'h80ff8000);
		chk(q[10], 32'h5a3c_0000);
		chk(32'(u_card.pu), 32'h0);
		chk(32'(dat3_oe_r), 32'h0);
		$display("test good init done");
	end
	endtask
	task t_type;
	begin
		type_hi = 8'h01;
		run(0);
		chk(32'(fail_r), 32'h1);
		chk(32'(done_r), 32'h0);
		type_hi = 8'h00;
		$display("test card type done");
	end
	endtask
	task t_mute;
	begin
		mute = 1'b1;
		run(0);
		chk(32'(fail_r), 32'h1);
		mute = 1'b0;
		$display("test timeout done");
	end
	endtask
	task summarize;
	begin
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	initial
	begin
		#1000000;
		mismatches = mismatches + 1;
		summarize;
	end
	initial
	begin
		repeat (12) @(posedge clock);
		#1 sys_rst = 1'b0;
		t_good;
		t_type;
		t_mute;
		summarize;
	end
endmodule // tb
